/* core/rtcdc_pkg.sv */
// Constants for the real-time clock divider chain.
// Assumes a single system clock and a power-on reset only.
package rtcdc_pkg;
   localparam int NSTG = 5;
   // Stage 0 is the prescaler timer, stages 1..4 form the 32-bit count
   localparam int STG_W   [NSTG] = '{16, 10, 6, 6, 10};
   localparam int STG_OFS [NSTG] = '{0, 0, 10, 16, 22};
   localparam int CNT_W    = 32;
   localparam int WORD_W   = 16;
   localparam int HALF_OFS = 16;
   localparam int DIV32_W  = 5;
   localparam int DIV8_W   = 3;
   localparam logic [DIV32_W-1:0] DIV32_LAST = 5'h1f;
   localparam logic [DIV8_W-1:0]  DIV8_LAST  = 3'h7;
   localparam logic [DIV32_W-1:0] DIV32_RST  = 5'h00;
   localparam logic [DIV8_W-1:0]  DIV8_RST   = 3'h0;
   localparam logic [1:0] SRC_SYS  = 2'h0;
   localparam logic [1:0] SRC_INT  = 2'h1;
   localparam logic [1:0] SRC_EXT0 = 2'h2;
   localparam logic [1:0] SRC_EXT1 = 2'h3;
   localparam int NPIN = 3;
endpackage

/* core/rtcdc_stage.sv */
// One reloadable up-counting stage of the chain.
// Assumes tick and load are synchronous to clk.
`timescale 1ns/1ps
module rtcdc_stage #(
   parameter int W = 16
) (
   input wire logic  clk,
   input wire logic  rst_n,
   rtcdc_stage_if.stg sp
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         ovf;
   } rtcdc_stage_state_t;

   rtcdc_stage_state_t s_reg;
   rtcdc_stage_state_t s_next;

   if (W < 2) begin : g_chk
      $error("Stage width too small");
   end

   always_comb begin
      s_next     = s_reg;
      s_next.ovf = 1'b0;
      if (sp.load) begin
         s_next.cnt = sp.load_val;
      end else if (sp.tick) begin
         if (s_reg.cnt == {W{1'b1}}) begin
            s_next.cnt = sp.reload_val;
            s_next.ovf = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sp.value = s_reg.cnt;
   assign sp.ovf   = s_reg.ovf;
endmodule

/* core/rtcdc_stage_if.sv */
// Carrier between the chain controller and one reloadable stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rtcdc_stage_if #(parameter int W = 16);
   logic         tick;
   logic         load;
   logic [W-1:0] load_val;
   logic [W-1:0] reload_val;
   logic [W-1:0] value;
   logic         ovf;
   modport ctl (output tick, output load, output load_val, output reload_val, input value, input ovf);
   modport stg (input tick, input load, input load_val, input reload_val, output value, output ovf);
endinterface

/* core/rtcdc_top.sv */
// Real-time clock divider chain: source select, prescalers, prescaler timer, 32-bit count.
// Assumes RST_N is the power reset; other resets are not wired to this block.
//
// Functional notes
// - Chain clock is chosen from system clock, internal source pin or external pins.
// - A 32:1 and an 8:1 prescaler head the chain, each bypassable.
// - A reloadable 16-bit prescaler timer follows the prescalers.
// - The 32-bit count is written and read as high and low words.
// - The 32-bit count is stages of 10, 6, 6 and 10 bits, low first.
// - Every stage counts upward.
// - Each stage raises its own interrupt request on overflow.
// - All stage requests merge into one common interrupt node output.
// - Stage counter state is cleared only by the power reset; the prescaler counters also clear while bypassed.
`timescale 1ns/1ps
module rtcdc_top (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [1:0]  SRC_SEL,
   input  wire logic        SRC_INT_PIN,
   input  wire logic        SRC_EXT0_PIN,
   input  wire logic        SRC_EXT1_PIN,
   input  wire logic        DIV32_EN,
   input  wire logic        DIV8_EN,
   input  wire logic [15:0] RELOAD_PT,
   input  wire logic [31:0] RELOAD_CNT,
   input  wire logic        WR_PT,
   input  wire logic        WR_HIGH,
   input  wire logic        WR_LOW,
   input  wire logic [15:0] WR_DATA,
   output logic      [15:0] COUNT_HIGH_WORD,
   output logic      [15:0] COUNT_LOW_WORD,
   output logic      [15:0] PRESCALER_TIMER,
   output logic      [4:0]  STAGE_IRQ,
   output logic             IRQ_NODE
);
   localparam int NSTG = rtcdc_pkg::NSTG;
   localparam int NPIN = rtcdc_pkg::NPIN;

   typedef struct packed {
      logic [NPIN-1:0]                 sync1;
      logic [NPIN-1:0]                 sync2;
      logic [NPIN-1:0]                 sync3;
      logic [rtcdc_pkg::DIV32_W-1:0]   div32;
      logic [rtcdc_pkg::DIV8_W-1:0]    div8;
      logic [rtcdc_pkg::WORD_W-1:0]    hi;
      logic [rtcdc_pkg::WORD_W-1:0]    lo;
      logic [rtcdc_pkg::WORD_W-1:0]    pt;
      logic [NSTG-1:0]                 irq;
      logic                            node;
   } rtcdc_top_state_t;

   rtcdc_top_state_t                s_reg;
   rtcdc_top_state_t                s_next;
   logic [NPIN-1:0]                 src_rise;
   logic                            src_tick;
   logic                            div32_tick;
   logic                            head_tick;
   logic [NSTG-1:0]                 tick;
   logic [NSTG-1:0]                 ovf;
   wire logic [rtcdc_pkg::CNT_W-1:0] cnt_val;
   logic [rtcdc_pkg::WORD_W-1:0]    pt_val;
   logic [rtcdc_pkg::CNT_W-1:0]     wr_word;

   // Pick the count event of the selected source
   function automatic logic sel_tick(input logic [1:0] sel, input logic [NPIN-1:0] rise);
      logic t;
      t = 1'b0;
      unique case (sel)
         rtcdc_pkg::SRC_SYS:  t = 1'b1;
         rtcdc_pkg::SRC_INT:  t = rise[0];
         rtcdc_pkg::SRC_EXT0: t = rise[1];
         rtcdc_pkg::SRC_EXT1: t = rise[2];
      endcase
      return t;
   endfunction

   // Edge detect reads only synchronised copies
   assign src_rise   = s_reg.sync2 & ~s_reg.sync3;
   assign src_tick   = sel_tick(SRC_SEL, src_rise);
   assign div32_tick = DIV32_EN ? (src_tick && (s_reg.div32 == rtcdc_pkg::DIV32_LAST)) : src_tick;
   assign head_tick  = DIV8_EN ? (div32_tick && (s_reg.div8 == rtcdc_pkg::DIV8_LAST)) : div32_tick;
   assign wr_word    = {WR_DATA, WR_DATA};

   // Stage 0 is ticked by the prescaler output; each later stage is ticked by the overflow pulse of the one before
   assign tick = {ovf[NSTG-2:0], head_tick};

   for (genvar g = 0; g < NSTG; g++) begin : g_stage
      localparam int W = rtcdc_pkg::STG_W[g];
      localparam int O = rtcdc_pkg::STG_OFS[g];
      rtcdc_stage_if #(.W(W)) sif ();
      rtcdc_stage #(.W(W)) u_stage (
         .clk   (CLK),
         .rst_n (RST_N),
         .sp    (sif.stg)
      );
      assign sif.tick = tick[g];
      assign ovf[g]   = sif.ovf;
      if (g == 0) begin : g_pt
         // Prescaler timer
         assign sif.load       = WR_PT;
         assign sif.load_val   = WR_DATA[W-1:0];
         assign sif.reload_val = RELOAD_PT[W-1:0];
         assign pt_val         = sif.value;
      end else begin : g_cnt
         // Stages of the 32-bit count, placed by bit offset
         assign sif.load       = (O < rtcdc_pkg::HALF_OFS) ? WR_LOW : WR_HIGH;
         assign sif.load_val   = wr_word[O+W-1:O];
         assign sif.reload_val = RELOAD_CNT[O+W-1:O];
         assign cnt_val[O+W-1:O] = sif.value;
      end
   end

   always_comb begin
      s_next       = s_reg;
      s_next.sync1 = {SRC_EXT1_PIN, SRC_EXT0_PIN, SRC_INT_PIN};
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      // Prescaler counters hold at zero while bypassed
      if (!DIV32_EN) begin
         s_next.div32 = rtcdc_pkg::DIV32_RST;
      end else if (src_tick) begin
         s_next.div32 = s_reg.div32 + 1'b1;
      end
      if (!DIV8_EN) begin
         s_next.div8 = rtcdc_pkg::DIV8_RST;
      end else if (div32_tick) begin
         s_next.div8 = s_reg.div8 + 1'b1;
      end
      s_next.hi   = cnt_val[rtcdc_pkg::CNT_W-1:rtcdc_pkg::HALF_OFS];
      s_next.lo   = cnt_val[rtcdc_pkg::HALF_OFS-1:0];
      s_next.pt   = pt_val;
      s_next.irq  = ovf;
      s_next.node = |ovf;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign COUNT_HIGH_WORD = s_reg.hi;
   assign COUNT_LOW_WORD  = s_reg.lo;
   assign PRESCALER_TIMER = s_reg.pt;
   assign STAGE_IRQ       = s_reg.irq;
   assign IRQ_NODE        = s_reg.node;
endmodule

/* verif/rtcdc_asserts.sv */
// Port checker for the divider chain top level.
// Assumes a bind to rtcdc_top; RST_N is the power reset.
`timescale 1ns/1ps
module rtcdc_asserts (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [1:0]  SRC_SEL,
   input wire logic        DIV32_EN,
   input wire logic        DIV8_EN,
   input wire logic [15:0] RELOAD_PT,
   input wire logic [31:0] RELOAD_CNT,
   input wire logic        WR_PT,
   input wire logic        WR_HIGH,
   input wire logic        WR_LOW,
   input wire logic [15:0] WR_DATA,
   input wire logic [15:0] COUNT_HIGH_WORD,
   input wire logic [15:0] COUNT_LOW_WORD,
   input wire logic [15:0] PRESCALER_TIMER,
   input wire logic [4:0]  STAGE_IRQ,
   input wire logic        IRQ_NODE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   AST_NODE: assert property (IRQ_NODE == (|STAGE_IRQ)) else $error("node");
   AST_PULSE: assert property (STAGE_IRQ[0] && RELOAD_PT != 16'hffff |=> !STAGE_IRQ[0]) else $error("pulse");
   AST_UP: assert property ((SRC_SEL == 2'h0 && !DIV32_EN && !DIV8_EN && !WR_PT)[*3] ##0
      PRESCALER_TIMER != 16'hffff |=> PRESCALER_TIMER == $past(PRESCALER_TIMER) + 16'h1) else $error("up");
   AST_PT_RLD: assert property (STAGE_IRQ[0] |-> PRESCALER_TIMER == $past(RELOAD_PT, 2)) else $error("pt");
   AST_S1_RLD: assert property (STAGE_IRQ[1] |-> COUNT_LOW_WORD[9:0] == $past(RELOAD_CNT[9:0], 2)) else $error("s1");
   AST_CARRY: assert property (STAGE_IRQ[1] && !$past(WR_LOW) |=> COUNT_LOW_WORD[15:10] ==
      ($past(COUNT_LOW_WORD[15:10]) == 6'h3f ? $past(RELOAD_CNT[15:10], 2) :
      $past(COUNT_LOW_WORD[15:10]) + 6'h1)) else $error("carry");
   AST_LOW_WR: assert property (WR_LOW ##1 !WR_LOW ##1 !STAGE_IRQ[0] |-> COUNT_LOW_WORD == $past(WR_DATA, 2))
      else $error("low");
   AST_HIGH_WR: assert property (WR_HIGH ##1 !WR_HIGH ##1 !STAGE_IRQ[2] |-> COUNT_HIGH_WORD == $past(WR_DATA, 2))
      else $error("high");
endmodule
bind rtcdc_top rtcdc_asserts i_rtcdc_asserts (.CLK(CLK), .RST_N(RST_N), .SRC_SEL(SRC_SEL), .DIV32_EN(DIV32_EN),
   .DIV8_EN(DIV8_EN), .RELOAD_PT(RELOAD_PT), .RELOAD_CNT(RELOAD_CNT), .WR_PT(WR_PT), .WR_HIGH(WR_HIGH),
   .WR_LOW(WR_LOW), .WR_DATA(WR_DATA), .COUNT_HIGH_WORD(COUNT_HIGH_WORD), .COUNT_LOW_WORD(COUNT_LOW_WORD),
   .PRESCALER_TIMER(PRESCALER_TIMER), .STAGE_IRQ(STAGE_IRQ), .IRQ_NODE(IRQ_NODE));

/* verif/tb_rtcdc_top.sv */
// Testbench for the divider chain top level.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/1ps
module tb_rtcdc_top;
   logic        clk;
   logic        rst_n;
   logic [1:0]  src_sel;
   logic [2:0]  pins;
   logic        div32_en;
   logic        div8_en;
   logic [15:0] reload_pt;
   logic [31:0] reload_cnt;
   logic [2:0]  wr;
   logic [15:0] wr_data;
   logic [15:0] hi_w;
   logic [15:0] lo_w;
   logic [15:0] pt_w;
   logic [4:0]  irq;
   logic        node;
   int          failures = 0;
   int          n_compared = 0;
   rtcdc_top i_rtcdc_top (.CLK(clk), .RST_N(rst_n), .SRC_SEL(src_sel), .SRC_INT_PIN(pins[0]),
      .SRC_EXT0_PIN(pins[1]), .SRC_EXT1_PIN(pins[2]), .DIV32_EN(div32_en), .DIV8_EN(div8_en),
      .RELOAD_PT(reload_pt), .RELOAD_CNT(reload_cnt), .WR_PT(wr[2]), .WR_HIGH(wr[1]), .WR_LOW(wr[0]),
      .WR_DATA(wr_data), .COUNT_HIGH_WORD(hi_w), .COUNT_LOW_WORD(lo_w), .PRESCALER_TIMER(pt_w),
      .STAGE_IRQ(irq), .IRQ_NODE(node));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic write(input logic [2:0] s, input logic [15:0] d);
      wr = s;
      wr_data = d;
      cyc(1);
      wr = 3'h0;
      cyc(1);
   endtask
   task automatic pulse(input logic [2:0] p);
      pins = p;
      cyc(2);
      pins = 3'h0;
      cyc(2);
   endtask
   task automatic wchg(output int c);
      logic [15:0] v;
      v = pt_w;
      c = 0;
      while (pt_w === v) begin
         cyc(1);
         c++;
         if (c > 600) begin
            failures++;
            results;
         end
      end
   endtask
   task automatic t_chain;
      logic [4:0] seen;
      int         nodes;
      reload_cnt = 32'h01030801;
      reload_pt = 16'h0100;
      write(3'h7, 16'hffff);
      seen = 5'h0;
      nodes = 0;
      src_sel = 2'h0;
      repeat (40) begin
         cyc(1);
         seen |= irq;
         if (node === 1'b1) nodes++;
      end
      src_sel = 2'h1;
      cyc(2);
      chk("irqs", 16'h1f, {11'h0, seen});
      chk("node", 16'h5, 16'(nodes));
      chk("high", 16'h0103, hi_w);
      chk("low", 16'h0801, lo_w);
   endtask
   task automatic t_div;
      int c;
      src_sel = 2'h0;
      for (int m = 1; m < 4; m++) begin
         {div8_en, div32_en} = 2'(m);
         repeat (3) wchg(c);
         chk("period", m == 1 ? 16'h20 : m == 2 ? 16'h8 : 16'h100, 16'(c));
      end
      {div8_en, div32_en} = 2'h0;
   endtask
   task automatic t_pins;
      for (int k = 1; k < 4; k++) begin
         src_sel = 2'(k);
         write(3'h4, 16'h0);
         repeat (3) pulse(3'h1 << (k - 1));
         pulse(~(3'h1 << (k - 1)));
         cyc(4);
         chk("pin count", 16'h3, pt_w);
      end
   endtask
   initial begin
      {rst_n, div32_en, div8_en, pins, wr} = 9'h0;
      {reload_pt, reload_cnt, wr_data} = 64'h0;
      src_sel = 2'h1;
      cyc(4);
      rst_n = 1'b1;
      cyc(2);
      chk("reset", 16'h0, hi_w | lo_w | pt_w);
      t_chain;
      t_div;
      t_pins;
      results;
   end
endmodule
